// [core/timer_evt_defs.svh]
`ifndef TIMER_EVT_DEFS_SVH
`define TIMER_EVT_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------------
`define OFS_COUNT_LO 3'h0
`define OFS_COUNT_HI 3'h1
`define OFS_CONTROL 3'h2
`define OFS_TBSEL 3'h3
`define OFS_FLAGS2 3'h4
`define OFS_ENABLES2 3'h5

// ----------------------------------------------------------------------
// Field positions and write masks
// ----------------------------------------------------------------------
`define BIT_RUN 0
`define BIT_WIDE 1
`define BIT_SYNC_DIS 2
`define BIT_PS_LO 4
`define BIT_PS_HI 5
`define BIT_CS_LO 6
`define BIT_CS_HI 7
`define BIT_OVF 1
`define BIT_TB_LO 0
`define BIT_TB_HI 1
`define CTRL_WMASK 8'hF7
`define TB_WMASK 8'h03

// ----------------------------------------------------------------------
// Values and reset values
// ----------------------------------------------------------------------
`define MODE_SPECIAL 4'hB
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000
`define COUNT_ONE 16'h0001
`define BYTE_ZERO 8'h00
`define DIV_LAST 2'h3
`define DIV_ONE 2'h1
`define DIV_ZERO 2'h0
`define PS_LIM_1 3'h0
`define PS_LIM_2 3'h1
`define PS_LIM_4 3'h3
`define PS_LIM_8 3'h7
`define PS_ZERO 3'h0
`define PS_ONE 3'h1

`endif

// [core/timer_evt_pkg.sv]
`include "timer_evt_defs.svh"

package timer_evt_pkg;

    // ------------------------------------------------------------------
    // Count source selection, taken from the two top control bits
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_INSTR = 2'b00,
        SRC_SYS = 2'b01,
        SRC_EXT = 2'b10,
        SRC_RSVD = 2'b11
    } src_e;

    // Whole state of the timer block.
    typedef struct packed {
        logic [15:0] count;
        logic [7:0] hi_buf;
        logic [7:0] control;
        logic [7:0] tbsel;
        logic ovf_flag;
        logic ovf_en;
        logic [7:0] rdata;
        logic irq;
        logic adc_start;
        logic ext_prev;
        logic [1:0] instr_div;
    } timer_s;

    // Whole state of the prescaler.
    typedef struct packed {
        logic [2:0] cnt;
        logic tick;
    } presc_s;

endpackage

// [core/tick_prescaler.sv]
`timescale 1ns/100ps
`include "timer_evt_defs.svh"

// Divides count source pulses by 1, 2, 4 or 8 into one-cycle ticks.
module tick_prescaler (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic src_pulse,
    input wire logic restart,
    input wire logic [1:0] ratio_sel,
    output logic tick
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    timer_evt_pkg::presc_s q; // Registered state.
    timer_evt_pkg::presc_s d; // Next state.

    // Last count value before a tick for each ratio.
    function automatic logic [2:0] ratio_limit(input logic [1:0] sel);
        logic [2:0] lim;
        case (sel)
            2'b00: lim = `PS_LIM_1;
            2'b01: lim = `PS_LIM_2;
            2'b10: lim = `PS_LIM_4;
            default: lim = `PS_LIM_8;
        endcase
        return lim;
    endfunction

    // Restart wins so that a count write starts a clean prescale period.
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (restart) begin
            d.cnt = `PS_ZERO;
        end else if (src_pulse) begin
            if (q.cnt >= ratio_limit(ratio_sel)) begin
                d.cnt = `PS_ZERO;
                d.tick = 1'b1;
            end else begin
                d.cnt = 3'(q.cnt + `PS_ONE);
            end
        end
    end

    // Register the whole state.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

// [core/timer_compare_event_reset.sv]
`timescale 1ns/100ps
`include "timer_evt_defs.svh"

module timer_compare_event_reset (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic count_in,
    input wire logic [3:0] unit_one_mode,
    input wire logic [15:0] unit_one_value,
    input wire logic [3:0] unit_two_mode,
    input wire logic [15:0] unit_two_value,
    input wire logic adc_enabled,
    output logic adc_start,
    output logic [15:0] count_value,
    output logic irq
);

    // ------------------------------------------------------------------
    // State and helper signals
    // ------------------------------------------------------------------
    timer_evt_pkg::timer_s q; // Registered state.
    timer_evt_pkg::timer_s d; // Next state.
    timer_evt_pkg::src_e src; // Selected count source.
    logic src_pulse; // One source event before prescaling.
    logic tick; // One counting increment.
    logic run; // Counting enabled.
    logic wide; // Buffered sixteen-bit access mode.
    logic cnt_wr; // Software write lands in the count this cycle.
    logic sync_ok; // Trigger clear is guaranteed in this mode.
    logic match_one; // Unit one special-event match.
    logic match_two; // Unit two special-event match.
    logic trig_one; // Unit one trigger that clears.
    logic trig_two; // Unit two trigger that clears.
    logic restart; // Prescaler restart.

    // ------------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------------
    // Timebase select: 00 neither unit, 01 unit two only, 1x both units.
    function automatic logic uses_timer(input logic [1:0] sel, input logic unit_two);
        return sel[`BIT_TB_HI] | (sel[`BIT_TB_LO] & unit_two);
    endfunction

    // A unit fires when it uses this timer, is in special-event mode and
    // its compare value equals the count.
    function automatic logic unit_match(input logic [1:0] sel, input logic unit_two,
                                        input logic [3:0] mode, input logic [15:0] value,
                                        input logic [15:0] count);
        return uses_timer(sel, unit_two) && (mode == `MODE_SPECIAL) && (value == count);
    endfunction

    // Read data for one register; unmapped offsets read as zero.
    function automatic logic [7:0] read_mux(input logic [2:0] addr,
                                            input timer_evt_pkg::timer_s s,
                                            input logic wide_mode);
        logic [7:0] v;
        v = `BYTE_ZERO;
        case (addr)
            `OFS_COUNT_LO: v = s.count[7:0];
            `OFS_COUNT_HI: v = wide_mode ? s.hi_buf : s.count[15:8];
            `OFS_CONTROL: v = s.control;
            `OFS_TBSEL: v = s.tbsel;
            `OFS_FLAGS2: v[`BIT_OVF] = s.ovf_flag;
            `OFS_ENABLES2: v[`BIT_OVF] = s.ovf_en;
            default: v = `BYTE_ZERO;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Source selection and trigger qualification
    // ------------------------------------------------------------------
    // The external input is taken as synchronous; a rising edge counts.
    always_comb begin
        src = timer_evt_pkg::src_e'(q.control[`BIT_CS_HI:`BIT_CS_LO]);
        run = q.control[`BIT_RUN];
        wide = q.control[`BIT_WIDE];
        case (src)
            timer_evt_pkg::SRC_INSTR: src_pulse = (q.instr_div == `DIV_LAST);
            timer_evt_pkg::SRC_SYS: src_pulse = 1'b1;
            timer_evt_pkg::SRC_EXT: src_pulse = count_in & ~q.ext_prev;
            default: src_pulse = 1'b0;
        endcase
        cnt_wr = reg_wr && ((reg_addr == `OFS_COUNT_LO) ||
                            ((reg_addr == `OFS_COUNT_HI) && !wide));
        // Unsynchronised clear skipped.
        // The clear is withheld rather than left racy, so its absence is
        // at least predictable for software.
        sync_ok = !((src == timer_evt_pkg::SRC_EXT) && q.control[`BIT_SYNC_DIS]);
        match_one = unit_match(q.tbsel[1:0], 1'b0, unit_one_mode, unit_one_value, q.count);
        match_two = unit_match(q.tbsel[1:0], 1'b1, unit_two_mode, unit_two_value, q.count);
        trig_one = match_one && sync_ok;
        trig_two = match_two && sync_ok;
        restart = !run || cnt_wr;
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    tick_prescaler u_prescaler (
        .clk(clk),
        .sys_rst(sys_rst),
        .src_pulse(src_pulse && run),
        .restart(restart),
        .ratio_sel(q.control[`BIT_PS_HI:`BIT_PS_LO]),
        .tick(tick)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Counting, register access and interrupt state all resolve here so
    // that their priorities are visible in one place.
    always_comb begin
        d = q;
        d.ext_prev = count_in;
        d.instr_div = (q.instr_div == `DIV_LAST) ? `DIV_ZERO : 2'(q.instr_div + `DIV_ONE);
        d.rdata = `BYTE_ZERO;
        d.adc_start = 1'b0;

        // Counting increment; a write below overrides the count.
        if (tick) begin
            if (trig_one || trig_two) begin
                d.count = `COUNT_ZERO;
            end else begin
                d.count = 16'(q.count + `COUNT_ONE);
                if (q.count == `COUNT_MAX) begin
                    d.ovf_flag = 1'b1;
                end
            end
            d.adc_start = trig_two && adc_enabled;
        end

        // Register writes.
        if (reg_wr) begin
            case (reg_addr)
                `OFS_COUNT_LO: begin
                    if (wide) begin
                        d.count = {q.hi_buf, reg_wdata};
                    end else begin
                        d.count[7:0] = reg_wdata;
                    end
                end
                `OFS_COUNT_HI: begin
                    // Buffered mode holds the high byte until the low write.
                    if (wide) begin
                        d.hi_buf = reg_wdata;
                    end else begin
                        d.count[15:8] = reg_wdata;
                    end
                end
                `OFS_CONTROL: begin
                    d.control = reg_wdata & `CTRL_WMASK;
                end
                `OFS_TBSEL: begin
                    d.tbsel = reg_wdata & `TB_WMASK;
                end
                `OFS_FLAGS2: begin
                    // Write one to clear; a same-cycle overflow still wins.
                    if (reg_wdata[`BIT_OVF] && !(tick && !trig_one && !trig_two &&
                                                 (q.count == `COUNT_MAX))) begin
                        d.ovf_flag = 1'b0;
                    end
                end
                `OFS_ENABLES2: begin
                    d.ovf_en = reg_wdata[`BIT_OVF];
                end
                default: begin
                    // Unmapped writes are ignored.
                end
            endcase
        end

        // Register reads; a low-byte read in buffered mode snaps the high byte.
        if (reg_rd) begin
            d.rdata = read_mux(reg_addr, q, wide);
            if (wide && (reg_addr == `OFS_COUNT_LO)) begin
                d.hi_buf = q.count[15:8];
            end
        end

        d.irq = d.ovf_flag && d.ovf_en;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Every output is a field of the registered state.
    assign reg_rdata = q.rdata;
    assign adc_start = q.adc_start;
    assign count_value = q.count;
    assign irq = q.irq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_trig_clears_count: assert property (
        (tick && trig_one && !cnt_wr) |=> (count_value == `COUNT_ZERO))
        else $error("unit one trigger did not clear the count");

    a_adc_start_cause: assert property (
        adc_start |-> $past(tick && trig_two && adc_enabled))
        else $error("converter start without an enabled unit two trigger");

    a_period_repeat: assert property (
        (tick && match_two && sync_ok && !cnt_wr && !reg_wr)
            |=> (count_value == `COUNT_ZERO) && (unit_two_value != `COUNT_MAX ||
                                                 !$rose(irq)))
        else $error("compare value did not end the period");

    a_unsync_no_clear: assert property (
        (tick && !sync_ok && !cnt_wr && q.count != `COUNT_MAX)
            |=> (count_value == $past(q.count) + `COUNT_ONE))
        else $error("unsynchronised count was disturbed");

    a_write_wins: assert property (
        (reg_wr && reg_addr == `OFS_COUNT_LO && !wide && tick && (trig_one || trig_two))
            |=> (count_value[7:0] == $past(reg_wdata)))
        else $error("trigger clear overrode a count write");

    a_clear_no_flag: assert property (
        (tick && (trig_one || trig_two) && !q.ovf_flag) |=> !q.ovf_flag)
        else $error("trigger clear set the overflow flag");

    a_count_step: assert property (
        (tick && !trig_one && !trig_two && !cnt_wr)
            |=> (count_value == 16'($past(q.count) + `COUNT_ONE)))
        else $error("count did not step by one");

    a_wrap_sets_flag: assert property (
        (tick && !trig_one && !trig_two && !cnt_wr && q.count == `COUNT_MAX)
            |=> (count_value == `COUNT_ZERO) && q.ovf_flag)
        else $error("wrap did not latch the overflow flag");

    a_irq_gated: assert property (
        irq == (q.ovf_flag && q.ovf_en))
        else $error("interrupt disagrees with flag and enable");

    a_read_slot: assert property (
        !$past(reg_rd) |-> (reg_rdata == `BYTE_ZERO))
        else $error("read data outside its cycle");

    // A flag-clear write must not swallow an overflow in the same cycle.
    a_set_beats_clear: assert property (
        (reg_wr && reg_addr == `OFS_FLAGS2 && reg_wdata[`BIT_OVF] && tick &&
         !trig_one && !trig_two && !cnt_wr && q.count == `COUNT_MAX) |=> q.ovf_flag)
        else $error("flag clear overrode a same-cycle overflow");

    // A unit two trigger while the converter is off must stay quiet.
    a_no_start_disabled: assert property (
        (tick && trig_two && !adc_enabled) |=> !adc_start)
        else $error("converter start while the converter is off");

    // Only unit two may start the converter.
    a_unit_one_quiet: assert property (
        (tick && trig_one && !trig_two) |=> !adc_start)
        else $error("unit one trigger started the converter");

    // Without an increment or a write the count must hold.
    a_count_hold: assert property (
        (!tick && !reg_wr) |=> (count_value == $past(q.count)))
        else $error("count moved without an increment");

    // Control reads return the stored control byte one cycle later.
    a_control_read: assert property (
        (reg_rd && reg_addr == `OFS_CONTROL) |=> (reg_rdata == $past(q.control)))
        else $error("control read returned a wrong byte");

    // The write-beats-clear race and unsynchronised counting are worth seeing.
    c_write_wins: cover property (reg_wr && reg_addr == `OFS_COUNT_LO && tick && trig_two);
    c_unsync_count: cover property (tick && !sync_ok);

    c_trigger_clear: cover property (tick && trig_one ##1 count_value == `COUNT_ZERO);
    c_adc_start: cover property (adc_start);
    c_overflow: cover property ($rose(q.ovf_flag));
    c_irq: cover property ($rose(irq));

endmodule

// [testbench/compare_adc_model.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Stand-in for both compare units and the converter
// ----------------------------------------------------------------------
// The compare levels are held by the model and set through setup().
module compare_adc_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic adc_start,
    output logic [3:0] unit_one_mode,
    output logic [15:0] unit_one_value,
    output logic [3:0] unit_two_mode,
    output logic [15:0] unit_two_value,
    output logic adc_enabled,
    output int starts
);
    // Quiet levels at time zero, so no match can fire before setup.
    initial begin
        {unit_one_mode, unit_one_value, unit_two_mode, unit_two_value} = '0;
        adc_enabled = 1'b0;
    end

    // Levels change right after an edge, as the real units would do.
    task automatic setup(input logic [3:0] m1, input logic [15:0] v1,
                         input logic [3:0] m2, input logic [15:0] v2, input logic en);
        @(posedge clk);
        unit_one_mode <= m1;
        unit_one_value <= v1;
        unit_two_mode <= m2;
        unit_two_value <= v2;
        adc_enabled <= en;
    endtask

    // every start pulse counted
    // Pulses seen while disabled are counted too, so a stray start shows.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            starts <= 0;
        end else if (adc_start === 1'b1) begin
            starts <= starts + 1;
        end
    end
endmodule

// [testbench/timer_compare_event_reset_test.sv]
`timescale 1ns/100ps
`include "timer_evt_defs.svh"

// Bench for the event-cleared timer.
module timer_compare_event_reset_test;
    logic clk, sys_rst, reg_wr, reg_rd, count_in, adc_enabled, adc_start, irq, pulse_on;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    logic [3:0] unit_one_mode, unit_two_mode;
    logic [15:0] unit_one_value, unit_two_value, count_value, top;
    int starts, wraps, s0, mismatches, checks;

    timer_compare_event_reset timer_compare_event_reset_inst (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .count_in(count_in), .unit_one_mode(unit_one_mode),
        .unit_one_value(unit_one_value), .unit_two_mode(unit_two_mode),
        .unit_two_value(unit_two_value), .adc_enabled(adc_enabled), .adc_start(adc_start),
        .count_value(count_value), .irq(irq));
    compare_adc_model compare_adc_model_inst (.clk(clk), .sys_rst(sys_rst),
        .adc_start(adc_start), .unit_one_mode(unit_one_mode),
        .unit_one_value(unit_one_value), .unit_two_mode(unit_two_mode),
        .unit_two_value(unit_two_value), .adc_enabled(adc_enabled), .starts(starts));

    // ------------------------------------------------------------------
    // Clock, external input and shared tasks
    // ------------------------------------------------------------------
    // A 100 ns period.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // The external input toggles each cycle while enabled, one rise per two cycles.
    always @(posedge clk) begin
        if (pulse_on) begin
            count_in <= ~count_in;
        end
    end

    // Compares and reports one value.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle write strobe.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read strobe; the data stand only in the following cycle.
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    // Watches the count for n cycles, keeping its peak and its returns to zero.
    task automatic watch(input int n);
        logic [15:0] prev;
        prev = count_value;
        top = '0;
        wraps = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (count_value > top) top = count_value;
            if (count_value == 16'h0000 && prev != 16'h0000) wraps++;
            prev = count_value;
        end
    endtask

    // Stops the timer and clears the count between scenarios.
    task automatic halt();
        wr(`OFS_CONTROL, 8'h00);
        wr(`OFS_COUNT_LO, 8'h00);
        wr(`OFS_COUNT_HI, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, write masks and an unmapped place.
    task automatic t_regs();
        for (int a = 0; a < 7; a++) begin
            rd(3'(a));
            check("reset value", rd_val, 16'h0000);
        end
        wr(`OFS_CONTROL, 8'hFF);
        rd(`OFS_CONTROL);
        check("control mask", rd_val, 16'h00F7);
        wr(`OFS_TBSEL, 8'hFF);
        rd(`OFS_TBSEL);
        check("tbsel mask", rd_val, 16'h0003);
        wr(3'h6, 8'h55);
        rd(3'h6);
        check("unmapped", rd_val, 16'h0000);
        halt();
    endtask

    // Unit two as period source, converter on then off.
    task automatic t_period();
        compare_adc_model_inst.setup(4'h0, 16'h0000, 4'hB, 16'h0002, 1'b1);
        wr(`OFS_TBSEL, 8'h01);
        wr(`OFS_CONTROL, 8'h41);
        s0 = starts;
        watch(30);
        check("period peak", top, 16'h0002);
        check("wrapped", 16'(wraps >= 8), 16'h0001);
        // The model counts a start one edge after the pulse, so let that edge pass.
        @(posedge clk);
        #1;
        check("starts", 16'(starts - s0), 16'(wraps));
        compare_adc_model_inst.setup(4'h0, 16'h0000, 4'hB, 16'h0002, 1'b0);
        // A start already in flight when the converter is switched off is not counted.
        repeat (2) @(posedge clk);
        #1 s0 = starts;
        watch(12);
        check("starts off", 16'(starts - s0), 16'h0000);
        rd(`OFS_FLAGS2);
        check("no flag", rd_val, 16'h0000);
        halt();
    endtask

    // Unit one clears only when it uses this timer and the mode is special.
    task automatic t_units();
        compare_adc_model_inst.setup(4'hB, 16'h0003, 4'h0, 16'h0000, 1'b1);
        s0 = starts;
        wr(`OFS_CONTROL, 8'h41);
        watch(12);
        check("other base", 16'(top > 16'h3), 16'h0001);
        halt();
        wr(`OFS_TBSEL, 8'h02);
        wr(`OFS_CONTROL, 8'h41);
        watch(12);
        check("unit one peak", top, 16'h0003);
        check("unit one starts", 16'(starts - s0), 16'h0000);
        halt();
        compare_adc_model_inst.setup(4'hA, 16'h0003, 4'h0, 16'h0000, 1'b1);
        wr(`OFS_CONTROL, 8'h41);
        watch(12);
        check("other mode", 16'(top > 16'h3), 16'h0001);
        halt();
    endtask

    // A count write in the trigger cycle wins over the clear.
    task automatic t_write();
        compare_adc_model_inst.setup(4'h0, 16'h0000, 4'hB, 16'h0002, 1'b1);
        wr(`OFS_TBSEL, 8'h01);
        wr(`OFS_CONTROL, 8'h41);
        repeat (20) begin
            @(posedge clk);
            #1;
            if (count_value == 16'h0001) break;
        end
        wr(`OFS_COUNT_LO, 8'h50);
        #1 check("write wins", count_value, 16'h0050);
        halt();
    endtask

    // Unsynchronised external counting skips the clear; synchronised keeps it.
    task automatic t_extern();
        // Unit two in special-event mode on this timer gives a period of three.
        compare_adc_model_inst.setup(4'h0, 16'h0000, 4'hB, 16'h0002, 1'b0);
        wr(`OFS_TBSEL, 8'h01);
        pulse_on <= 1'b1;
        wr(`OFS_CONTROL, 8'h85);
        watch(24);
        check("unsync", 16'(top > 16'h2), 16'h0001);
        halt();
        wr(`OFS_CONTROL, 8'h81);
        watch(30);
        check("sync peak", top, 16'h0002);
        halt();
        pulse_on <= 1'b0;
    endtask

    // Overflow wraps, latches the flag and raises the interrupt only when enabled.
    task automatic t_ovf();
        compare_adc_model_inst.setup(4'h0, 16'h0000, 4'h0, 16'h0000, 1'b0);
        wr(`OFS_COUNT_LO, 8'hFE);
        wr(`OFS_COUNT_HI, 8'hFF);
        wr(`OFS_CONTROL, 8'h41);
        watch(6);
        check("wrap", 16'(wraps), 16'h0001);
        rd(`OFS_FLAGS2);
        check("flag set", rd_val, 16'h0002);
        check("irq masked", 16'(irq), 16'h0000);
        wr(`OFS_ENABLES2, 8'h02);
        repeat (2) @(posedge clk);
        #1 check("irq on", 16'(irq), 16'h0001);
        wr(`OFS_FLAGS2, 8'h02);
        repeat (2) @(posedge clk);
        #1 check("irq cleared", 16'(irq), 16'h0000);
        rd(`OFS_FLAGS2);
        check("flag cleared", rd_val, 16'h0000);
        halt();
    endtask

    // ------------------------------------------------------------------
    // Main sequence, watchdog and verdict
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // The run needs well under a thousand cycles; five thousand means a hang.
    initial begin
        #(100 * 5000);
        mismatches++;
        final_report();
    end

    // Reset for five cycles, then the scenarios in turn.
    initial begin
        {sys_rst, reg_wr, reg_rd, count_in, pulse_on} = 5'b10000;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        mismatches = 0;
        checks = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_period();
        t_units();
        t_write();
        t_extern();
        t_ovf();
        final_report();
    end
endmodule
